/* pkg/isr_pkg.sv */
package isr_pkg;

	// ----------------------------------------------------------------
	// register space
	// ----------------------------------------------------------------
	localparam int REG_AW = 5;
	localparam int DATA_W = 8;
	localparam logic [4:0] ADDR_RSVD0 = 5'h00;
	localparam logic [4:0] ADDR_RSVD1 = 5'h01;
	localparam logic [4:0] ADDR_UNLOCK = 5'h02;
	localparam logic [4:0] ADDR_WDCFG = 5'h03;
	localparam logic [4:0] ADDR_LAST = 5'h1f;
	localparam logic [4:0] ADDR_WRAP = 5'h00; // pointer after the last one
	localparam logic [4:0] PTR_RST = 5'h00;
	localparam logic [7:0] UNLOCK_KEY = 8'h5a;
	localparam logic [7:0] UNLOCK_RST = 8'h00;
	localparam logic [7:0] WDCFG_RST = 8'h09;
	localparam int TOUT_LSB = 3; // timeout period field is bits 5:3

	// ----------------------------------------------------------------
	// link
	// ----------------------------------------------------------------
	localparam logic [6:0] SLAVE_ADDR_DEF = 7'h00;
	localparam logic [6:0] SLAVE_ADDR_MAX = 7'h7e;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] LAST_TX_BIT = 4'h7;
	localparam logic LINE_IDLE = 1'b1; // released bus line reads high
	localparam int CLK_KHZ = 25000;

	// ----------------------------------------------------------------
	// timeout watchdog period, milliseconds
	// ----------------------------------------------------------------
	localparam logic [11:0] TOUT_MS_0 = 12'h050;
	localparam logic [11:0] TOUT_MS_1 = 12'h0a0;
	localparam logic [11:0] TOUT_MS_2 = 12'h140;
	localparam logic [11:0] TOUT_MS_3 = 12'h1e0;
	localparam logic [11:0] TOUT_MS_4 = 12'h320;
	localparam logic [11:0] TOUT_MS_5 = 12'h3e8;
	localparam logic [11:0] TOUT_MS_6 = 12'h7d0;
	localparam logic [11:0] TOUT_MS_7 = 12'hfa0;
	localparam logic [11:0] TOUT_MS_RST = TOUT_MS_1;

	typedef enum logic [7:0] {
		ST_IDLE = 8'h01,
		ST_ADDR = 8'h02,
		ST_PTR = 8'h04,
		ST_WDATA = 8'h08,
		ST_ACK = 8'h10,
		ST_READ = 8'h20,
		ST_MACK = 8'h40,
		ST_IGNORE = 8'h80
	} isr_state_t;

	function automatic logic [11:0] isr_tout_ms(input logic [2:0] code);
		logic [11:0] ms;
		ms = TOUT_MS_0;
		case (code)
			3'h0: ms = TOUT_MS_0;
			3'h1: ms = TOUT_MS_1;
			3'h2: ms = TOUT_MS_2;
			3'h3: ms = TOUT_MS_3;
			3'h4: ms = TOUT_MS_4;
			3'h5: ms = TOUT_MS_5;
			3'h6: ms = TOUT_MS_6;
			default: ms = TOUT_MS_7;
		endcase
		return ms;
	endfunction : isr_tout_ms

endpackage : isr_pkg

/* src/isr_i2c_slave.sv */
`timescale 1ns/10ps
module isr_i2c_slave #(
	parameter logic [6:0] SLAVE_ADDR = isr_pkg::SLAVE_ADDR_DEF
) (
	input wire logic clk, // system clock, 25 MHz
	input wire logic rstn, // async reset, active low
	input wire logic sclIn, // bus clock pin level
	input wire logic sdaIn, // bus data pin level
	output logic sdaOut, // data pin drive value, always low
	output logic sdaOe, // high while pulling the data line low
	output logic busBusy, // high between start and stop
	output logic [7:0] wdConfig, // watchdog configuration register
	output logic [11:0] wdTimeoutMs // timeout watchdog period, ms
);

	isr_pkg::isr_state_t state;
	isr_pkg::isr_state_t next_state;
	isr_pkg::isr_state_t afterAck;
	isr_pkg::isr_state_t next_afterAck;
	logic sclS;
	logic sdaS;
	logic sclPrev;
	logic sdaPrev;
	logic sclRise;
	logic sclFall;
	logic startDet;
	logic stopDet;
	logic [3:0] bitCnt;
	logic [3:0] next_bitCnt;
	logic [7:0] rxShift;
	logic [7:0] next_rxShift;
	logic [7:0] txShift;
	logic [7:0] next_txShift;
	logic [4:0] ptr;
	logic [4:0] next_ptr;
	logic masterAck;
	logic next_masterAck;
	logic next_sdaOe;
	logic next_busBusy;
	logic [11:0] next_wdTimeoutMs;
	logic wrEn;
	logic [7:0] rdData;

	// ----------------------------------------------------------------
	// pin capture and bus conditions
	// ----------------------------------------------------------------
	isr_sync #(
		.WIDTH(2)
	) u_sync (
		.clk(clk),
		.rstn(rstn),
		.din({sclIn, sdaIn}),
		.dout({sclS, sdaS})
	);

	// previous levels feed the edge detectors
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sclPrev <= isr_pkg::LINE_IDLE;
			sdaPrev <= isr_pkg::LINE_IDLE;
		end else begin
			sclPrev <= sclS;
			sdaPrev <= sdaS;
		end
	end

	assign sclRise = sclS & ~sclPrev;
	assign sclFall = ~sclS & sclPrev;
	// data edges count as conditions only with the clock high both samples
	assign startDet = sclS & sclPrev & sdaPrev & ~sdaS;
	assign stopDet = sclS & sclPrev & ~sdaPrev & sdaS;

	// ----------------------------------------------------------------
	// register space
	// ----------------------------------------------------------------
	// the whole map hangs off this port's pointer
	isr_regfile u_regs (
		.clk(clk),
		.rstn(rstn),
		.wrEn(wrEn),
		.wrAddr(ptr),
		.wrData(rxShift),
		.rdAddr(ptr),
		.rdData(rdData),
		.wdConfig(wdConfig)
	);

	function automatic logic [4:0] ptr_inc(input logic [4:0] p);
		return (p == isr_pkg::ADDR_LAST) ? isr_pkg::ADDR_WRAP :
			p + 5'h01;
	endfunction : ptr_inc

	// ----------------------------------------------------------------
	// transfer state machine
	// ----------------------------------------------------------------
	// start and stop override every state, so a master can abort anywhere
	always_comb begin
		next_state = state;
		next_afterAck = afterAck;
		next_bitCnt = bitCnt;
		next_rxShift = rxShift;
		next_txShift = txShift;
		next_ptr = ptr;
		next_masterAck = masterAck;
		next_sdaOe = sdaOe;
		next_busBusy = busBusy;
		wrEn = 1'b0;
		if (startDet) begin
			next_state = isr_pkg::ST_ADDR; // also a repeated start
			next_bitCnt = 4'h0;
			next_sdaOe = 1'b0;
			next_busBusy = 1'b1;
		end else if (stopDet) begin
			next_state = isr_pkg::ST_IDLE;
			next_sdaOe = 1'b0;
			next_busBusy = 1'b0;
		end else begin
			case (state)
				isr_pkg::ST_ADDR, isr_pkg::ST_PTR, isr_pkg::ST_WDATA: begin
					// sample on rising clock while data is stable
					if (sclRise && bitCnt < isr_pkg::BITS_PER_BYTE) begin
						next_rxShift = {rxShift[6:0], sdaS};
						next_bitCnt = bitCnt + 4'h1;
					end else if (sclFall && bitCnt == isr_pkg::BITS_PER_BYTE) begin
						next_bitCnt = 4'h0;
						next_state = isr_pkg::ST_ACK;
						next_sdaOe = 1'b1;
						if (state == isr_pkg::ST_ADDR) begin
							// only our own address; no general call handling
							if (rxShift[7:1] == SLAVE_ADDR) begin
								next_afterAck = rxShift[0] ?
									isr_pkg::ST_READ : isr_pkg::ST_PTR;
							end else begin
								next_state = isr_pkg::ST_IGNORE;
								next_sdaOe = 1'b0;
							end
						end else if (state == isr_pkg::ST_PTR) begin
							next_ptr = rxShift[isr_pkg::REG_AW-1:0];
							next_afterAck = isr_pkg::ST_WDATA;
						end else begin
							wrEn = 1'b1;
							next_ptr = ptr_inc(ptr);
							next_afterAck = isr_pkg::ST_WDATA;
						end
					end
				end
				isr_pkg::ST_ACK: begin
					// release at the start of the low phase of the 9th pulse
					if (sclFall) begin
						next_sdaOe = 1'b0;
						next_state = afterAck;
						if (afterAck == isr_pkg::ST_READ) begin
							next_txShift = rdData;
							next_ptr = ptr_inc(ptr);
							next_sdaOe = ~rdData[7];
							next_bitCnt = 4'h0;
						end
					end
				end
				isr_pkg::ST_READ: begin
					// next bit goes out on each falling clock
					if (sclFall) begin
						if (bitCnt == isr_pkg::LAST_TX_BIT) begin
							next_sdaOe = 1'b0;
							next_state = isr_pkg::ST_MACK;
						end else begin
							next_txShift = {txShift[6:0], 1'b0};
							next_sdaOe = ~txShift[6];
							next_bitCnt = bitCnt + 4'h1;
						end
					end
				end
				isr_pkg::ST_MACK: begin
					if (sclRise) begin
						next_masterAck = ~sdaS;
					end else if (sclFall) begin
						if (masterAck) begin
							next_state = isr_pkg::ST_READ;
							next_txShift = rdData;
							next_ptr = ptr_inc(ptr);
							next_sdaOe = ~rdData[7];
							next_bitCnt = 4'h0;
						end else begin
							// nack: wait for the master's start or stop
							next_state = isr_pkg::ST_IGNORE;
						end
					end
				end
				isr_pkg::ST_IDLE, isr_pkg::ST_IGNORE: begin
					next_sdaOe = 1'b0;
				end
				default: begin
					next_state = isr_pkg::ST_IDLE;
					next_sdaOe = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state <= isr_pkg::ST_IDLE;
			afterAck <= isr_pkg::ST_PTR;
			bitCnt <= 4'h0;
			rxShift <= 8'h00;
			txShift <= 8'h00;
			ptr <= isr_pkg::PTR_RST;
			masterAck <= 1'b0;
			sdaOe <= 1'b0;
			busBusy <= 1'b0;
		end else begin
			state <= next_state;
			afterAck <= next_afterAck;
			bitCnt <= next_bitCnt;
			rxShift <= next_rxShift;
			txShift <= next_txShift;
			ptr <= next_ptr;
			masterAck <= next_masterAck;
			sdaOe <= next_sdaOe;
			busBusy <= next_busBusy;
		end
	end

	// ----------------------------------------------------------------
	// watchdog period decode
	// ----------------------------------------------------------------
	// registered so the output is glitch free while config is rewritten
	always_comb begin
		next_wdTimeoutMs = isr_pkg::isr_tout_ms(
			wdConfig[isr_pkg::TOUT_LSB +: 3]);
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wdTimeoutMs <= isr_pkg::TOUT_MS_RST;
			sdaOut <= 1'b0;
		end else begin
			wdTimeoutMs <= next_wdTimeoutMs;
			sdaOut <= 1'b0; // open drain: only ever pulls low
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	a_start_busy: assert property (startDet |=> busBusy &&
		state == isr_pkg::ST_ADDR && !sdaOe)
		else $error("start did not open a transfer");
	a_stop_free: assert property (stopDet && !startDet |=>
		!busBusy && state == isr_pkg::ST_IDLE)
		else $error("stop did not free the bus");
	a_addr_ack: assert property (state == isr_pkg::ST_ADDR &&
		sclFall && bitCnt == 4'h8 && !startDet && !stopDet &&
		rxShift[7:1] == SLAVE_ADDR |=> sdaOe && state == isr_pkg::ST_ACK)
		else $error("own address not acknowledged");
	a_foreign_nack: assert property (state == isr_pkg::ST_ADDR &&
		sclFall && bitCnt == 4'h8 && rxShift[7:1] != SLAVE_ADDR
		|=> !sdaOe [*2])
		else $error("foreign address acknowledged");
	a_ack_release: assert property (state == isr_pkg::ST_ACK &&
		sclFall && afterAck != isr_pkg::ST_READ |=> !sdaOe)
		else $error("ack not released after ninth pulse");
	a_tx_release: assert property (state == isr_pkg::ST_READ &&
		sclFall && bitCnt == 4'h7 && !startDet && !stopDet
		|=> !sdaOe && state == isr_pkg::ST_MACK)
		else $error("data line held after eighth bit");
	a_sda_on_fall: assert property ($changed(sdaOe) |->
		$past(sclFall) || $past(startDet) || $past(stopDet))
		else $error("data line moved outside clock low");
	a_ptr_wrap: assert property (state == isr_pkg::ST_WDATA &&
		sclFall && bitCnt == 4'h8 && ptr == isr_pkg::ADDR_LAST &&
		!startDet && !stopDet |=> ptr == isr_pkg::ADDR_WRAP)
		else $error("pointer did not wrap");
	a_msb_first: assert property (state == isr_pkg::ST_ACK && sclFall &&
		afterAck == isr_pkg::ST_READ && !startDet && !stopDet
		|=> sdaOe == ~$past(rdData[7]))
		else $error("read byte not msb first");
	a_period_map: assert property (wdConfig[5:3] == 3'h2
		|=> wdTimeoutMs == isr_pkg::TOUT_MS_2)
		else $error("timeout period decode wrong");

	c_write: cover property (wrEn);
	c_read_burst: cover property (state == isr_pkg::ST_MACK && sclFall &&
		masterAck);
	c_foreign: cover property (state == isr_pkg::ST_IGNORE && busBusy);
	c_rep_start: cover property (busBusy && startDet);

endmodule : isr_i2c_slave

/* src/isr_regfile.sv */
`timescale 1ns/10ps
module isr_regfile (
	input wire logic clk, // system clock
	input wire logic rstn, // async reset, active low
	input wire logic wrEn, // one-cycle write strobe
	input wire logic [4:0] wrAddr, // write register address
	input wire logic [7:0] wrData, // write data
	input wire logic [4:0] rdAddr, // read register address
	output logic [7:0] rdData, // read data, combinational
	output logic [7:0] wdConfig // watchdog configuration register
);

	logic [7:0] unlock;
	logic [7:0] next_unlock;
	logic [7:0] next_wdConfig;

	// ----------------------------------------------------------------
	// write side
	// ----------------------------------------------------------------
	// config only takes a write while the key sits in the unlock register
	always_comb begin
		next_unlock = unlock;
		next_wdConfig = wdConfig;
		if (wrEn && wrAddr == isr_pkg::ADDR_UNLOCK) begin
			next_unlock = wrData;
		end
		if (wrEn && wrAddr == isr_pkg::ADDR_WDCFG &&
				unlock == isr_pkg::UNLOCK_KEY) begin
			next_wdConfig = wrData;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			unlock <= isr_pkg::UNLOCK_RST;
			wdConfig <= isr_pkg::WDCFG_RST;
		end else begin
			unlock <= next_unlock;
			wdConfig <= next_wdConfig;
		end
	end

	// ----------------------------------------------------------------
	// read side
	// ----------------------------------------------------------------
	// reserved and unimplemented locations read as zero
	always_comb begin
		case (rdAddr)
			isr_pkg::ADDR_UNLOCK: rdData = unlock;
			isr_pkg::ADDR_WDCFG: rdData = wdConfig;
			default: rdData = 8'h00;
		endcase
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_lock_blocks: assert property (@(posedge clk) disable iff (!rstn)
		wrEn && wrAddr == isr_pkg::ADDR_WDCFG &&
		unlock != isr_pkg::UNLOCK_KEY |=> $stable(wdConfig))
		else $error("locked watchdog config changed");
	a_key_opens: assert property (@(posedge clk) disable iff (!rstn)
		wrEn && wrAddr == isr_pkg::ADDR_WDCFG &&
		unlock == isr_pkg::UNLOCK_KEY |=> wdConfig == $past(wrData))
		else $error("unlocked watchdog config write lost");

endmodule : isr_regfile

/* src/isr_sync.sv */
`timescale 1ns/10ps
module isr_sync #(
	parameter int WIDTH = 2
) (
	input wire logic clk, // system clock
	input wire logic rstn, // async reset, active low
	input wire logic [WIDTH-1:0] din, // asynchronous pin levels
	output logic [WIDTH-1:0] dout // levels after two flops
);

	// ----------------------------------------------------------------
	// two-flop synchroniser per line
	// ----------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			logic meta;
			logic stable;
			// reset to the released level so no false edge follows reset
			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					meta <= isr_pkg::LINE_IDLE;
					stable <= isr_pkg::LINE_IDLE;
				end else begin
					meta <= din[i];
					stable <= meta;
				end
			end
			// one driver per output bit, straight from the second flop
			assign dout[i] = stable;
		end
	endgenerate

endmodule : isr_sync

/* tb/i2c_slave_register_access_bench.sv */
`timescale 1ns/10ps
module i2c_slave_register_access_bench;
	localparam logic [6:0] SA = 7'h2d; // legal non-zero slave address
	logic clk;
	logic rstn;
	logic scl;
	logic sdaRel;
	logic sdaWire;
	logic sdaOut;
	logic sdaOe;
	logic busBusy;
	logic [7:0] wdConfig;
	logic [11:0] wdTimeoutMs;
	logic [15:0] seed;
	int nMismatch;
	int comparisons;
	logic [11:0] msTab [0:7];
	logic [7:0] exp5 [0:4];
	logic [7:0] d;
	logic [7:0] v;
	logic [6:0] fa;

	// open-drain data line: any low driver wins over the pull-up
	assign sdaWire = (sdaOe ? sdaOut : 1'b1) & sdaRel;

	isr_i2c_slave #(.SLAVE_ADDR(SA)) uut (
		.clk(clk),
		.rstn(rstn),
		.sclIn(scl),
		.sdaIn(sdaWire),
		.sdaOut(sdaOut),
		.sdaOe(sdaOe),
		.busBusy(busBusy),
		.wdConfig(wdConfig),
		.wdTimeoutMs(wdTimeoutMs)
	);

	isr_host_model host (
		.clk(clk),
		.sdaWire(sdaWire),
		.scl(scl),
		.sdaRel(sdaRel)
	);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	function automatic logic [7:0] rnd();
		seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
		return seed[7:0];
	endfunction : rnd

	function automatic logic [11:0] expMs(input logic [2:0] c);
		return msTab[c];
	endfunction : expMs

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			nMismatch++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic wrapUp();
		if (nMismatch == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : wrapUp

	// one byte out, the acknowledge seen must match
	task automatic wb(input logic [7:0] b, input logic expNack);
		logic a;
		host.wrByte(b, a);
		chk({15'h0, a}, {15'h0, expNack});
	endtask : wb

	// pointer reserved bits get random values, they must not matter
	task automatic wrReg(input logic [4:0] p, input logic [7:0] b);
		host.start();
		wb({SA, 1'b0}, 1'b0);
		wb({rnd() & 8'he0} | {3'h0, p}, 1'b0);
		wb(b, 1'b0);
		chk({15'h0, sdaOe}, 16'h0);
		chk({15'h0, sdaOut}, 16'h0);
		host.stop();
	endtask : wrReg

	task automatic rdReg(input logic [4:0] p, output logic [7:0] b);
		host.start();
		wb({SA, 1'b0}, 1'b0);
		wb({3'h0, p}, 1'b0);
		host.start();
		wb({SA, 1'b1}, 1'b0);
		host.rdByte(1'b1, b);
		host.stop();
	endtask : rdReg

	// a hang cannot outlive this bound
	initial begin
		repeat (100000) @(posedge clk);
		nMismatch++;
		wrapUp();
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		rstn = 1'b0;
		seed = 16'h5d12;
		nMismatch = 0;
		comparisons = 0;
		msTab = '{12'h050, 12'h0a0, 12'h140, 12'h1e0,
			12'h320, 12'h3e8, 12'h7d0, 12'hfa0};
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
		chk({8'h0, wdConfig}, 16'h0009);
		chk({4'h0, wdTimeoutMs}, 16'h00a0);
		chk({15'h0, busBusy}, 16'h0);
		host.start();
		chk({15'h0, busBusy}, 16'h1);
		host.stop();
		chk({15'h0, busBusy}, 16'h0);
		rdReg(5'h02, d);
		chk({8'h0, d}, 16'h0000);
		// locked, then a near-miss key: both writes must be dropped
		wrReg(5'h03, 8'h3f);
		chk({8'h0, wdConfig}, 16'h0009);
		wrReg(5'h02, 8'h5b);
		wrReg(5'h03, 8'h00);
		chk({8'h0, wdConfig}, 16'h0009);
		wrReg(5'h02, 8'h5a);
		// every timeout code once, random neighbour bits
		for (int c = 0; c < 8; c++) begin
			v = rnd();
			v[5:3] = c[2:0];
			wrReg(5'h03, v);
			chk({8'h0, wdConfig}, {8'h0, v});
			chk({4'h0, wdTimeoutMs}, {4'h0, expMs(c[2:0])});
			rdReg(5'h03, d);
			chk({8'h0, d}, {8'h0, v});
		end
		// burst write across the top of the space wraps to zero
		v = rnd();
		host.start();
		wb({SA, 1'b0}, 1'b0);
		wb(8'hff, 1'b0);
		wb(rnd(), 1'b0);
		wb(rnd(), 1'b0);
		wb(rnd(), 1'b0);
		wb(8'h5a, 1'b0);
		wb(v, 1'b0);
		host.stop();
		chk({8'h0, wdConfig}, {8'h0, v});
		// burst read across the top, ended by a withheld acknowledge
		exp5 = '{8'h00, 8'h00, 8'h00, 8'h5a, v};
		host.start();
		wb({SA, 1'b0}, 1'b0);
		wb(8'h1f, 1'b0);
		host.stop();
		host.start();
		wb({SA, 1'b1}, 1'b0);
		for (int i = 0; i < 5; i++) begin
			host.rdByte(i == 4, d);
			chk({8'h0, d}, {8'h0, exp5[i]});
		end
		host.stop();
		// relock, then a write to the config must not land
		wrReg(5'h02, 8'h00);
		wrReg(5'h03, ~v);
		chk({8'h0, wdConfig}, {8'h0, v});
		// general call, start byte and a random foreign address
		fa = 7'(rnd());
		if (fa == SA) begin
			fa = fa ^ 7'h01;
		end
		for (int k = 0; k < 3; k++) begin
			host.start();
			wb(k == 0 ? 8'h00 : (k == 1 ? 8'h01 : {fa, 1'b0}), 1'b1);
			wb(8'h02, 1'b1);
			wb(8'h5a, 1'b1);
			host.stop();
		end
		rdReg(5'h02, d);
		chk({8'h0, d}, 16'h0000);
		// a mid-run reset must relock the config and restore its value
		wrReg(5'h02, 8'h5a);
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
		chk({8'h0, wdConfig}, 16'h0009);
		chk({4'h0, wdTimeoutMs}, 16'h00a0);
		chk({15'h0, busBusy}, 16'h0);
		wrReg(5'h03, 8'h3f);
		chk({8'h0, wdConfig}, 16'h0009);
		wrapUp();
	end

endmodule : i2c_slave_register_access_bench

/* tb/isr_host_model.sv */
`timescale 1ns/10ps
module isr_host_model #(
	parameter int HALF = 6
) (
	input wire logic clk, // system clock
	input wire logic sdaWire, // resolved data line
	output logic scl, // bus clock drive
	output logic sdaRel // high releases data, pull-up makes it high
);
	// ------------------------------------------------------------
	// bus phases
	// ------------------------------------------------------------
	// every phase is longer than the slave's sync and detect delay
	task automatic half();
		repeat (HALF) @(posedge clk);
	endtask : half

	// both lines idle high at time zero
	initial begin
		scl = 1'b1;
		sdaRel = 1'b1;
	end

	// start or repeated start, data falls while clock is high
	task automatic start();
		sdaRel <= 1'b1;
		half();
		scl <= 1'b1;
		half();
		sdaRel <= 1'b0;
		half();
		scl <= 1'b0;
		half();
	endtask : start

	// stop, data rises while clock is high
	task automatic stop();
		sdaRel <= 1'b0;
		half();
		scl <= 1'b1;
		half();
		sdaRel <= 1'b1;
		half();
	endtask : stop

	// one bit: data moves only in the low phase, sampled at end of high
	task automatic sendBit(input logic b, output logic r);
		sdaRel <= b;
		half();
		scl <= 1'b1;
		half();
		r = sdaWire;
		scl <= 1'b0;
		half();
	endtask : sendBit

	// byte out msb first, then release for the slave's acknowledge
	task automatic wrByte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			sendBit(d[i], r);
		end
		sendBit(1'b1, ack);
	endtask : wrByte

	// byte in msb first, then our acknowledge or a withheld one
	task automatic rdByte(input logic nack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			sendBit(1'b1, d[i]);
		end
		sendBit(nack, r);
	endtask : rdByte

endmodule : isr_host_model
